// >>> core/card_reader_pkg.sv
// Package: offsets, field positions, reset values and timing for the card reader tail
package card_reader_pkg;

  // ****************************************************
  // Register offsets (byte addresses)
  // ****************************************************
  localparam logic [11:0] OFF_CTRL_FLUSH     = 12'h014;
  localparam logic [11:0] OFF_RX_THRESHOLD   = 12'h01C;
  localparam logic [11:0] OFF_CARD_DIV       = 12'h024;
  localparam logic [11:0] OFF_BAUD_DIV       = 12'h028;
  localparam logic [11:0] OFF_IRQ_ENABLE2    = 12'h040;
  localparam logic [11:0] OFF_IRQ_STATUS2    = 12'h044;
  localparam logic [11:0] OFF_TX_THRESHOLD   = 12'h048;
  localparam logic [11:0] OFF_TX_FILL        = 12'h04C;
  localparam logic [11:0] OFF_RX_FILL        = 12'h050;
  localparam logic [11:0] OFF_BAUD_FRACTION  = 12'h054;
  localparam logic [11:0] OFF_STATUS_EXTRA   = 12'h058;
  localparam logic [11:0] FIFO_WINDOW_LO     = 12'h200;
  localparam logic [11:0] FIFO_WINDOW_HI     = 12'h3FF;

  // ****************************************************
  // Field positions and widths
  // ****************************************************
  localparam int          TX_FLUSH_BIT       = 2;
  localparam int          RX_FLUSH_BIT       = 10;
  localparam int          TX_EMPTY_BIT       = 0;
  localparam int          TX_FULL_BIT        = 1;
  localparam int          RX_EMPTY_BIT       = 8;
  localparam int          RX_FULL_BIT        = 9;
  localparam int          TX_LEVEL_BIT       = 0;
  localparam int          RX_LEVEL_BIT       = 1;
  localparam int          CARD_PRESENT_BIT   = 2;
  localparam int          FRACTION_W         = 3;
  localparam int          FRACTION_FIELD_W   = 4;
  localparam int          REG_W              = 16;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [15:0] RST_ZERO16         = 16'h0000;
  localparam logic [2:0]  RST_FRACTION       = 3'h0;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int          SYS_CLK_HZ         = 50000000;
  localparam int          MIN_BAUD_DIVISOR   = 4;

endpackage

// >>> core/byte_fifo.sv
// Byte FIFO with fill count, flush and a two-entry skid buffer on its output
`timescale 1ns/100ps
module byte_fifo #(
  parameter int DEPTH  = 256,
  parameter int DATA_W = 8,
  parameter int CNT_W  = 16
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // Fill side
  input  wire logic              in_valid_i,
  output logic                   in_ready_o,
  input  wire logic [DATA_W-1:0] in_data_i,
  // Drain side
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic      [DATA_W-1:0] out_data_o,
  // Control and status
  input  wire logic              flush_i,
  output logic      [CNT_W-1:0]  count_o,
  output logic                   full_o,
  output logic                   empty_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int SKID = 2;

  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [AW-1:0]     wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0]       mem_cnt_r, mem_cnt_nxt;
  logic [DATA_W-1:0] skid_r [SKID];
  logic [DATA_W-1:0] skid_nxt [SKID];
  logic [1:0]        skid_cnt_r, skid_cnt_nxt;
  logic              push, pop_out, move, skid_room;
  logic [AW:0]       total;

  // ****************************************************
  // Flow control
  // ****************************************************
  assign total       = mem_cnt_r + {{(AW-1){1'b0}}, skid_cnt_r};
  assign full_o      = (total == (AW+1)'(DEPTH));
  assign empty_o     = (total == '0);
  assign in_ready_o  = !full_o && !flush_i;
  assign push        = in_valid_i && in_ready_o;
  assign out_valid_o = (skid_cnt_r != 2'd0);
  assign out_data_o  = skid_r[0];
  assign pop_out     = out_valid_o && out_ready_i && !flush_i;
  // Refill the skid from memory; skid holds two so a stalled reader loses nothing
  assign skid_room   = (skid_cnt_r < 2'(SKID)) || pop_out;
  assign move        = (mem_cnt_r != '0) && skid_room && !flush_i;
  assign count_o     = CNT_W'(total);

  always_comb begin
    wr_ptr_nxt   = wr_ptr_r;
    rd_ptr_nxt   = rd_ptr_r;
    mem_cnt_nxt  = mem_cnt_r;
    skid_nxt     = skid_r;
    skid_cnt_nxt = skid_cnt_r;
    if (flush_i) begin
      wr_ptr_nxt   = '0;
      rd_ptr_nxt   = '0;
      mem_cnt_nxt  = '0;
      skid_cnt_nxt = 2'd0;
    end else begin
      if (push) begin
        wr_ptr_nxt = AW'(wr_ptr_r + 1'b1);
      end
      if (move) begin
        rd_ptr_nxt = AW'(rd_ptr_r + 1'b1);
      end
      mem_cnt_nxt = (AW+1)'(mem_cnt_r + push - move);
      if (pop_out) begin
        skid_nxt[0] = skid_r[1];
      end
      skid_cnt_nxt = 2'(skid_cnt_r + move - pop_out);
      if (move) begin
        skid_nxt[2'(skid_cnt_r - pop_out) == 2'd0 ? 0 : 1] = mem_r[rd_ptr_r];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
    skid_r <= skid_nxt;
    if (reset_i) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      mem_cnt_r  <= '0;
      skid_cnt_r <= 2'd0;
    end else begin
      wr_ptr_r   <= wr_ptr_nxt;
      rd_ptr_r   <= rd_ptr_nxt;
      mem_cnt_r  <= mem_cnt_nxt;
      skid_cnt_r <= skid_cnt_nxt;
    end
  end
endmodule

// >>> core/card_reader_clock_fifo.sv
// Card reader tail: card clock, baud impulses, byte FIFO window and fill levels
`timescale 1ns/100ps
module card_reader_clock_fifo
  import card_reader_pkg::*;
#(
  parameter int FIFO_DEPTH = 256
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // Register port
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [15:0] pwdata_i,
  output logic      [15:0] prdata_o,
  output logic             pready_o,
  // Card side
  output logic             card_clock_out_o,
  input  wire logic        card_detect_in_i,
  input  wire logic        soc_config_word7_i,
  output logic             card_present_o,
  // Character engine side
  output logic             baud_tick_o,
  output logic             tx_byte_valid_o,
  input  wire logic        tx_byte_ready_i,
  output logic      [7:0]  tx_byte_o,
  input  wire logic        rx_byte_valid_i,
  output logic             rx_byte_ready_o,
  input  wire logic [7:0]  rx_byte_i,
  // Interrupt lines
  output logic             tx_level_low_irq_o,
  output logic             rx_level_high_irq_o
);
  import card_reader_pkg::*;

  // ****************************************************
  // Registers
  // ****************************************************
  logic [15:0] tx_level_threshold_r, tx_level_threshold_nxt;
  logic [15:0] rx_level_threshold_r, rx_level_threshold_nxt;
  logic [15:0] card_clock_divisor_r, card_clock_divisor_nxt;
  logic [15:0] baud_divisor_r, baud_divisor_nxt;
  logic [2:0]  baud_fraction_r, baud_fraction_nxt;
  logic [1:0]  irq_enable_r, irq_enable_nxt;
  logic [15:0] prdata_r, prdata_nxt;
  logic        tx_flush, rx_flush;
  logic        access, wr, rd, in_window;
  logic [15:0] tx_fill_count, rx_fill_count;
  logic        tx_full, tx_empty, rx_full, rx_empty;
  logic        tx_push_ready, rx_pop_valid;
  logic [7:0]  rx_pop_data;
  logic        tx_level_low, rx_level_high;

  function automatic logic [15:0] zext(input logic [7:0] v);
    return {8'h00, v};
  endfunction

  assign access    = psel_i && penable_i;
  assign wr        = access && pwrite_i;
  assign rd        = access && !pwrite_i;
  assign pready_o  = 1'b1;
  assign in_window = (paddr_i >= FIFO_WINDOW_LO) && (paddr_i <= FIFO_WINDOW_HI);
  assign tx_flush  = wr && (paddr_i == OFF_CTRL_FLUSH) && pwdata_i[TX_FLUSH_BIT];
  assign rx_flush  = wr && (paddr_i == OFF_CTRL_FLUSH) && pwdata_i[RX_FLUSH_BIT];

  always_comb begin
    tx_level_threshold_nxt = tx_level_threshold_r;
    rx_level_threshold_nxt = rx_level_threshold_r;
    card_clock_divisor_nxt = card_clock_divisor_r;
    baud_divisor_nxt       = baud_divisor_r;
    baud_fraction_nxt      = baud_fraction_r;
    irq_enable_nxt         = irq_enable_r;
    if (wr) begin
      unique case (paddr_i)
        OFF_TX_THRESHOLD:  tx_level_threshold_nxt = pwdata_i;
        OFF_RX_THRESHOLD:  rx_level_threshold_nxt = pwdata_i;
        OFF_CARD_DIV:      card_clock_divisor_nxt = pwdata_i;
        OFF_BAUD_DIV:      baud_divisor_nxt = pwdata_i;
        OFF_BAUD_FRACTION: baud_fraction_nxt = pwdata_i[FRACTION_W-1:0];
        OFF_IRQ_ENABLE2:   irq_enable_nxt = pwdata_i[1:0];
        default: ;
      endcase
    end
  end

  // ****************************************************
  // Read mux
  // ****************************************************
  always_comb begin
    prdata_nxt = prdata_r;
    if (rd) begin
      prdata_nxt = RST_ZERO16;
      if (in_window) begin
        // pop returns the head byte; empty reads zero
        prdata_nxt = rx_pop_valid ? zext(rx_pop_data) : RST_ZERO16;
      end else begin
        unique case (paddr_i)
          OFF_TX_THRESHOLD:  prdata_nxt = tx_level_threshold_r;
          OFF_RX_THRESHOLD:  prdata_nxt = rx_level_threshold_r;
          OFF_CARD_DIV:      prdata_nxt = card_clock_divisor_r;
          OFF_BAUD_DIV:      prdata_nxt = baud_divisor_r;
          OFF_TX_FILL:       prdata_nxt = tx_fill_count;
          OFF_RX_FILL:       prdata_nxt = rx_fill_count;
          OFF_BAUD_FRACTION: prdata_nxt = {12'h000, 1'b0, baud_fraction_r};
          OFF_IRQ_ENABLE2:   prdata_nxt = {14'h0000, irq_enable_r};
          OFF_IRQ_STATUS2:   prdata_nxt = {14'h0000, rx_level_high, tx_level_low};
          OFF_CTRL_FLUSH:    prdata_nxt = {6'h00, rx_full, rx_empty, 6'h00, tx_full, tx_empty};
          OFF_STATUS_EXTRA:  prdata_nxt = {13'h0000, card_present_o, 2'b00};
          default:           prdata_nxt = RST_ZERO16;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_level_threshold_r <= RST_ZERO16;
      rx_level_threshold_r <= RST_ZERO16;
      card_clock_divisor_r <= RST_ZERO16;
      baud_divisor_r       <= RST_ZERO16;
      baud_fraction_r      <= RST_FRACTION;
      irq_enable_r         <= 2'b00;
      prdata_r             <= RST_ZERO16;
    end else begin
      tx_level_threshold_r <= tx_level_threshold_nxt;
      rx_level_threshold_r <= rx_level_threshold_nxt;
      card_clock_divisor_r <= card_clock_divisor_nxt;
      baud_divisor_r       <= baud_divisor_nxt;
      baud_fraction_r      <= baud_fraction_nxt;
      irq_enable_r         <= irq_enable_nxt;
      prdata_r             <= prdata_nxt;
    end
  end
  assign prdata_o = prdata_r;

  // ****************************************************
  // FIFOs
  // ****************************************************
  // full or empty accesses are dropped by the FIFO handshake
  byte_fifo #(.DEPTH(FIFO_DEPTH), .DATA_W(8), .CNT_W(REG_W)) tx_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (wr && in_window),
    .in_ready_o  (tx_push_ready),
    .in_data_i   (pwdata_i[7:0]),
    .out_valid_o (tx_byte_valid_o),
    .out_ready_i (tx_byte_ready_i),
    .out_data_o  (tx_byte_o),
    .flush_i     (tx_flush),
    .count_o     (tx_fill_count),
    .full_o      (tx_full),
    .empty_o     (tx_empty)
  );

  byte_fifo #(.DEPTH(FIFO_DEPTH), .DATA_W(8), .CNT_W(REG_W)) rx_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (rx_byte_valid_i),
    .in_ready_o  (rx_byte_ready_o),
    .in_data_i   (rx_byte_i),
    .out_valid_o (rx_pop_valid),
    .out_ready_i (rd && in_window),
    .out_data_o  (rx_pop_data),
    .flush_i     (rx_flush),
    .count_o     (rx_fill_count),
    .full_o      (rx_full),
    .empty_o     (rx_empty)
  );

  // ****************************************************
  // Levels, detect
  // ****************************************************
  // low-level compare, equality included
  assign tx_level_low        = (tx_fill_count <= tx_level_threshold_r);
  assign rx_level_high       = (rx_fill_count >= rx_level_threshold_r);
  assign tx_level_low_irq_o  = tx_level_low && irq_enable_r[TX_LEVEL_BIT];
  assign rx_level_high_irq_o = rx_level_high && irq_enable_r[RX_LEVEL_BIT];
  assign card_present_o      = soc_config_word7_i ? card_detect_in_i : !card_detect_in_i;

  // ****************************************************
  // Dividers
  // ****************************************************
  logic [15:0] card_cnt_r, card_cnt_nxt;
  logic        card_clk_r, card_clk_nxt;
  logic [16:0] baud_cnt_r, baud_cnt_nxt;
  logic [2:0]  frac_acc_r, frac_acc_nxt;
  logic        baud_tick_r, baud_tick_nxt;
  logic        stretch_r, stretch_nxt;
  logic [3:0]  frac_sum;

  // Period is 2*(div+1) clocks; fraction adds code/8 of a clock per period by accumulating
  // and stretching one clock on carry, so the jitter is one clock at most.
  assign frac_sum = {1'b0, frac_acc_r} + {1'b0, baud_fraction_r};

  always_comb begin
    // toggle every div+1 clocks; a new divisor acts at once, the flop never glitches
    card_cnt_nxt = 16'(card_cnt_r + 1'b1);
    card_clk_nxt = card_clk_r;
    if (card_cnt_r >= card_clock_divisor_r) begin
      card_cnt_nxt = RST_ZERO16;
      card_clk_nxt = !card_clk_r;
    end
    // impulse period 2*(div+1), plus one clock on fraction carry
    baud_cnt_nxt  = 17'(baud_cnt_r + 1'b1);
    baud_tick_nxt = 1'b0;
    frac_acc_nxt  = frac_acc_r;
    stretch_nxt   = stretch_r;
    if (stretch_r) begin
      stretch_nxt   = 1'b0;
      baud_cnt_nxt  = '0;
      baud_tick_nxt = 1'b1;
    end else if (baud_cnt_r >= 17'({baud_divisor_r, 1'b1})) begin
      baud_cnt_nxt = '0;
      frac_acc_nxt = frac_sum[2:0];
      if (frac_sum[3]) begin
        stretch_nxt = 1'b1;
      end else begin
        baud_tick_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      card_cnt_r  <= RST_ZERO16;
      card_clk_r  <= 1'b0;
      baud_cnt_r  <= '0;
      frac_acc_r  <= RST_FRACTION;
      baud_tick_r <= 1'b0;
      stretch_r   <= 1'b0;
    end else begin
      card_cnt_r  <= card_cnt_nxt;
      card_clk_r  <= card_clk_nxt;
      baud_cnt_r  <= baud_cnt_nxt;
      frac_acc_r  <= frac_acc_nxt;
      baud_tick_r <= baud_tick_nxt;
      stretch_r   <= stretch_nxt;
    end
  end
  assign card_clock_out_o = card_clk_r;
  assign baud_tick_o      = baud_tick_r;
endmodule

// >>> test/card_reader_clock_fifo_assertions.sv
// Checker: divider, tick, detect and readback relations at the card reader ports
`timescale 1ns/100ps
module card_reader_clock_fifo_assertions
  import card_reader_pkg::*;
(
  // Clock, reset and register port
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [15:0] pwdata_i,
  input wire logic [15:0] prdata_o,
  input wire logic        pready_o,
  // Card side, ticks and interrupt
  input wire logic        card_clock_out_o,
  input wire logic        card_detect_in_i,
  input wire logic        soc_config_word7_i,
  input wire logic        card_present_o,
  input wire logic        baud_tick_o,
  input wire logic        tx_level_low_irq_o
);
  logic        wr, rd, tog, cprev_r, txen_r;
  logic [15:0] cdiv_r, bdiv_r, thr_r;
  logic [2:0]  frac_r;
  logic [16:0] ccnt_r, bcnt_r;
  logic [1:0]  cseen_r, bseen_r;
  assign wr  = psel_i & penable_i & pwrite_i;
  assign rd  = psel_i & penable_i & ~pwrite_i;
  assign tog = card_clock_out_o ^ cprev_r;

  // ****************************************************
  // Shadow registers and interval counters
  // ****************************************************
  // Periods are judged only after two events past a write, since takeover may lag
  always_ff @(posedge sys_clk_i) begin
    cprev_r <= card_clock_out_o;
    ccnt_r  <= tog ? 17'h00000 : ccnt_r + 17'h00001;
    bcnt_r  <= baud_tick_o ? 17'h00000 : bcnt_r + 17'h00001;
    cseen_r <= (tog && cseen_r != 2'h2) ? cseen_r + 2'h1 : cseen_r;
    bseen_r <= (baud_tick_o && bseen_r != 2'h2) ? bseen_r + 2'h1 : bseen_r;
    cdiv_r  <= (wr && paddr_i == OFF_CARD_DIV) ? pwdata_i : cdiv_r;
    bdiv_r  <= (wr && paddr_i == OFF_BAUD_DIV) ? pwdata_i : bdiv_r;
    thr_r   <= (wr && paddr_i == OFF_TX_THRESHOLD) ? pwdata_i : thr_r;
    frac_r  <= (wr && paddr_i == OFF_BAUD_FRACTION) ? pwdata_i[2:0] : frac_r;
    txen_r  <= (wr && paddr_i == OFF_IRQ_ENABLE2) ? pwdata_i[0] : txen_r;
    if (wr && paddr_i == OFF_CARD_DIV) begin
      cseen_r <= 2'h0;
    end
    if (wr && (paddr_i == OFF_BAUD_DIV || paddr_i == OFF_BAUD_FRACTION)) begin
      bseen_r <= 2'h0;
    end
    if (reset_i) begin
      cprev_r <= 1'b0;
      ccnt_r  <= 17'h00000;
      bcnt_r  <= 17'h00000;
      cseen_r <= 2'h0;
      bseen_r <= 2'h0;
      cdiv_r  <= 16'h0000;
      bdiv_r  <= 16'h0000;
      thr_r   <= 16'h0000;
      frac_r  <= 3'h0;
      txen_r  <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  property p_present;
    card_present_o == (card_detect_in_i == soc_config_word7_i);
  endproperty
  a_present: assert property (p_present) else $error("card present level");
  property p_tick_pulse;
    baud_tick_o |=> !baud_tick_o;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  property p_baud_exact;
    baud_tick_o && bseen_r == 2'h2 && frac_r == 3'h0 |-> bcnt_r == {bdiv_r, 1'b1};
  endproperty
  a_baud_exact: assert property (p_baud_exact) else $error("baud period");
  property p_baud_frac;
    baud_tick_o && bseen_r == 2'h2 |-> bcnt_r - {bdiv_r, 1'b1} <= 17'h00001;
  endproperty
  a_baud_frac: assert property (p_baud_frac) else $error("tuned baud period");
  property p_card_half;
    tog && cseen_r == 2'h2 |-> ccnt_r == {1'b0, cdiv_r};
  endproperty
  a_card_half: assert property (p_card_half) else $error("card clock half period");
  property p_frac_read;
    rd && paddr_i == OFF_BAUD_FRACTION |=> prdata_o == {13'h0000, frac_r};
  endproperty
  a_frac_read: assert property (p_frac_read) else $error("fraction readback");
  property p_thr_read;
    rd && paddr_i == OFF_TX_THRESHOLD |=> prdata_o == thr_r;
  endproperty
  a_thr_read: assert property (p_thr_read) else $error("threshold readback");
  property p_irq_gate;
    !txen_r |-> !tx_level_low_irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked level irq");
  property p_no_wait;
    psel_i && penable_i |-> pready_o;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait state on register port");
endmodule

bind card_reader_clock_fifo card_reader_clock_fifo_assertions
  card_reader_clock_fifo_assertions_inst (
  .sys_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .card_clock_out_o, .card_detect_in_i, .soc_config_word7_i, .card_present_o,
  .baud_tick_o, .tx_level_low_irq_o);

// >>> test/engine_model.sv
// Character engine model: drains TX bytes with stalls and feeds queued RX bytes
`timescale 1ns/100ps
module engine_model (
  // Clock, reset and stall control
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       stall_i,
  // TX drain side
  input  wire logic       tx_byte_valid_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            tx_byte_ready_o = 1'b0,
  // RX fill side
  output logic            rx_byte_valid_o = 1'b0,
  input  wire logic       rx_byte_ready_i,
  output logic      [7:0] rx_byte_o = 8'h00
);
  logic [7:0] tx_got[$];
  logic [7:0] rx_q[$];
  // A byte stays until taken; idle data flips so a stale value never matches
  always @(posedge sys_clk_i) begin
    if (tx_byte_valid_i && tx_byte_ready_o) begin
      tx_got.push_back(tx_byte_i);
    end
    if (rx_byte_valid_o && rx_byte_ready_i) begin
      void'(rx_q.pop_front());
    end
    tx_byte_ready_o <= ~stall_i & ~reset_i;
    rx_byte_valid_o <= (rx_q.size() > 0) & ~reset_i;
    rx_byte_o <= (rx_q.size() > 0) ? rx_q[0] : ~rx_byte_o;
  end
endmodule

// >>> test/testbench.sv
// Testbench: registers, byte FIFOs, dividers and detect of the card reader tail
`timescale 1ns/100ps
module testbench;
  import card_reader_pkg::*;
  localparam int DEPTH = 8;
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [15:0] pwdata_i = 16'h0000;
  logic        card_detect_in_i = 1'b0;
  logic        soc_config_word7_i = 1'b0;
  logic        stall = 1'b1;
  logic [15:0] prdata_o;
  logic        card_clock_out_o, card_present_o, baud_tick_o, tx_irq, rx_irq;
  logic        tx_v, tx_r, rx_v, rx_r;
  logic [7:0]  tx_b, rx_b;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'h4B7F;
  int          n_mismatch = 0;
  int          tests_run = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  card_reader_clock_fifo #(.FIFO_DEPTH(DEPTH)) card_reader_clock_fifo_inst (
    .sys_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o(), .card_clock_out_o, .card_detect_in_i, .soc_config_word7_i,
    .card_present_o, .baud_tick_o, .tx_byte_valid_o(tx_v), .tx_byte_ready_i(tx_r),
    .tx_byte_o(tx_b), .rx_byte_valid_i(rx_v), .rx_byte_ready_o(rx_r), .rx_byte_i(rx_b),
    .tx_level_low_irq_o(tx_irq), .rx_level_high_irq_o(rx_irq));
  engine_model engine_model_inst (
    .sys_clk_i, .reset_i, .stall_i(stall), .tx_byte_valid_i(tx_v), .tx_byte_i(tx_b),
    .tx_byte_ready_o(tx_r), .rx_byte_valid_o(rx_v), .rx_byte_ready_i(rx_r), .rx_byte_o(rx_b));

  // ****************************************************
  // Expectations, bus access and reporting
  // ****************************************************
  function automatic logic [15:0] rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [15:0] fill(input int n);
    return (n > DEPTH) ? 16'(DEPTH) : 16'(n);
  endfunction
  function automatic int baud_cycles(input int b, input int code, input int k);
    return k * 2 * (b + 1) + k * code / 8;
  endfunction
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    chk(16'h0000, 16'h0001);
    end_of_test();
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 q = prdata_o;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask
  // Measures k periods, skipping the first one that a divisor change may stretch
  task automatic gap(input logic card, input int k, output int n);
    int seen;
    logic p, ev;
    seen = 0;
    n = 0;
    p = card_clock_out_o;
    for (int j = 0; j < 6000 && seen <= k + 1; j++) begin
      @(posedge sys_clk_i);
      #1;
      ev = card ? card_clock_out_o & ~p : baud_tick_o;
      p = card_clock_out_o;
      if (seen > 1) n++;
      if (ev === 1'b1) seen++;
    end
    if (seen <= k + 1) timeout();
  endtask

  initial begin
    logic [15:0] q, d;
    logic [11:0] regs[6];
    int n, m, c;
    regs = '{OFF_TX_THRESHOLD, OFF_CARD_DIV, OFF_BAUD_DIV, OFF_BAUD_FRACTION,
             OFF_TX_FILL, OFF_RX_FILL};
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(regs[i], 16'h0000);
      d = (rnd() & 16'h00FF) | 16'h0004;
      wr(regs[i], d);
      rd(regs[i], i > 3 ? 16'h0000 : (i == 3 ? d & 16'h0007 : d));
    end
    rd(12'h100, 16'h0000);
    // TX side: fill past full while stalled, then drain with random stalls
    wr(OFF_IRQ_ENABLE2, 16'h0003);
    wr(OFF_TX_THRESHOLD, 16'h0002);
    for (int i = 1; i <= DEPTH + 1; i++) begin
      d = rnd();
      if (i <= DEPTH) exp_q.push_back(d[7:0]);
      wr(i == 1 ? FIFO_WINDOW_LO : (i == 2 ? FIFO_WINDOW_HI : {3'b001, d[8:0]}), d);
      rd(OFF_TX_FILL, fill(i));
      chk(tx_irq, fill(i) <= 16'h0002);
    end
    for (n = 0; n < 400 && engine_model_inst.tx_got.size() < DEPTH; n++) begin
      @(posedge sys_clk_i);
      d = rnd();
      stall <= d[0];
    end
    if (n == 400) timeout();
    foreach (exp_q[i]) chk(engine_model_inst.tx_got[i], exp_q[i]);
    rd(OFF_IRQ_STATUS2, 16'h0003);
    exp_q.delete();
    // RX side: offer two more bytes than fit, then read all back
    wr(OFF_RX_THRESHOLD, 16'(DEPTH));
    for (int i = 0; i < DEPTH + 2; i++) begin
      d = rnd();
      exp_q.push_back(d[7:0]);
      engine_model_inst.rx_q.push_back(d[7:0]);
    end
    for (n = 0; n < 100 && rx_r !== 1'b0; n++) @(posedge sys_clk_i);
    if (n == 100) timeout();
    rd(OFF_RX_FILL, 16'(DEPTH));
    chk(rx_irq, 1'b1);
    wr(OFF_RX_THRESHOLD, 16'(DEPTH + 1));
    chk(rx_irq, 1'b0);
    foreach (exp_q[i]) begin
      d = rnd();
      bus(1'b0, {3'b001, d[8:0]}, 16'h0000, q);
      chk(q, {8'h00, exp_q[i]});
    end
    rd(FIFO_WINDOW_LO, 16'h0000);
    rd(OFF_RX_FILL, 16'h0000);
    // Flush both sides with bytes held in each
    stall <= 1'b1;
    wr(12'h2A0, 16'h005A);
    wr(12'h3C1, 16'h00C3);
    for (int i = 0; i < 3; i++) engine_model_inst.rx_q.push_back(8'(i));
    rd(OFF_CTRL_FLUSH, 16'h0000);
    wr(OFF_CTRL_FLUSH, 16'h0404);
    stall <= 1'b0;
    rd(OFF_TX_FILL, 16'h0000);
    rd(OFF_RX_FILL, 16'h0000);
    rd(OFF_CTRL_FLUSH, 16'h0101);
    chk(16'(engine_model_inst.tx_got.size()), 16'(DEPTH));
    // Dividers: first answer-to-reset bit time, then every fraction code
    c = rnd() & 16'h0001;
    wr(OFF_BAUD_FRACTION, 16'h0000);
    wr(OFF_CARD_DIV, 16'(c));
    wr(OFF_BAUD_DIV, 16'((c + 1) * 372 - 1));
    gap(1'b1, 1, m);
    chk(16'(m), 16'(2 * (c + 1)));
    gap(1'b0, 1, n);
    chk(16'(n), 16'(372 * m));
    c = (rnd() & 16'h0003) + 4;
    wr(OFF_BAUD_DIV, 16'(c));
    for (int code = 0; code < 8; code++) begin
      wr(OFF_BAUD_FRACTION, 16'(code));
      gap(1'b0, 8, n);
      chk(16'(n), 16'(baud_cycles(c, code, 8)));
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      soc_config_word7_i <= k[1];
      card_detect_in_i <= k[0];
      @(posedge sys_clk_i);
      #1;
      chk(card_present_o, k[1] == k[0]);
    end
    end_of_test();
  end
endmodule
